// file: core/adc_conversion_sequencer.sv
`default_nettype none
module adc_conversion_sequencer (
    // clock and reset
    input  wire logic                                i_clock,
    input  wire logic                                i_sys_rst,
    // control register one fields
    input  wire logic [adc_seq_pkg::PRESCALE_W-1:0]  i_sample_window_prescale,
    input  wire logic [adc_seq_pkg::CLKDIV_W-1:0]    i_converter_clock_divide,
    input  wire logic                                i_interrupt_enable,
    // trigger and flag control
    input  wire logic                                i_start_trigger,
    input  wire logic                                i_flag_clear,
    // analog front end
    input  wire logic [adc_seq_pkg::RESULT_W-1:0]    i_sample_code,
    output logic                                     o_sample_hold,
    output logic                                     o_converting,
    // results and status
    output logic [adc_seq_pkg::RESULT_W-1:0]         o_result,
    output logic                                     o_busy,
    output logic                                     o_done_flag,
    output logic                                     o_interrupt,
    output logic                                     o_cpu_clock_output
);
    // ****************************************
    // input synchronisers
    // ****************************************
    logic [1:0] trig_sync_ff;
    logic       trig_prev_ff;
    logic [1:0] clr_sync_ff;
    logic       trig_rise;

    always_ff @(posedge i_clock or posedge i_sys_rst)
    begin
        if (i_sys_rst)
        begin
            trig_sync_ff <= 2'h0;
            trig_prev_ff <= 1'b0;
            clr_sync_ff  <= 2'h0;
        end
        else
        begin
            trig_sync_ff <= {trig_sync_ff[0], i_start_trigger};
            trig_prev_ff <= trig_sync_ff[1];
            clr_sync_ff  <= {clr_sync_ff[0], i_flag_clear};
        end
    end

    assign trig_rise = trig_sync_ff[1] & ~trig_prev_ff;

    // ****************************************
    // helpers
    // ****************************************
    // clamp divide up so the converter clock never runs faster than allowed
    function automatic logic [adc_seq_pkg::CLKDIV_W-1:0] safe_div(
        input logic [adc_seq_pkg::CLKDIV_W-1:0] d);
        if (d < adc_seq_pkg::CLKDIV_W'(adc_seq_pkg::ADC_DIV_MIN))
            safe_div = adc_seq_pkg::CLKDIV_W'(adc_seq_pkg::ADC_DIV_MIN);
        else
            safe_div = d;
    endfunction

    // prescale 0 gives the shortest legal window, 30 and 31 the longest
    function automatic logic [5:0] window_ticks(
        input logic [adc_seq_pkg::PRESCALE_W-1:0] p);
        if (p > 5'h1E)
            window_ticks = 6'(adc_seq_pkg::SH_MAX_TICKS);
        else
            window_ticks = 6'(adc_seq_pkg::SH_MIN_TICKS) + {1'b0, p};
    endfunction

    // ****************************************
    // sequencer state
    // ****************************************
    adc_seq_pkg::seq_state_t              state_ff, nxt_state;
    logic [adc_seq_pkg::CLKDIV_W-1:0]     div_ff, nxt_div;
    logic [adc_seq_pkg::CLKDIV_W-1:0]     div_cnt_ff, nxt_div_cnt;
    logic [5:0]                           tick_cnt_ff, nxt_tick_cnt;
    logic [5:0]                           win_ff, nxt_win;
    logic [1:0]                           soc_cnt_ff, nxt_soc_cnt;
    logic [9:0]                           total_cnt_ff, nxt_total_cnt;
    logic [adc_seq_pkg::RESULT_W-1:0]     code_ff, nxt_code;
    logic                                 conv_end;
    logic                                 load_pulse;
    logic                                 adc_tick;

    assign adc_tick = (div_cnt_ff == div_ff - 4'h1);

    always_comb
    begin
        nxt_state     = state_ff;
        nxt_div       = div_ff;
        nxt_div_cnt   = adc_tick ? 4'h0 : div_cnt_ff + 4'h1;
        nxt_tick_cnt  = tick_cnt_ff;
        nxt_win       = win_ff;
        nxt_soc_cnt   = soc_cnt_ff;
        nxt_total_cnt = (total_cnt_ff == 10'h3FF) ? total_cnt_ff : total_cnt_ff + 10'h001;
        nxt_code      = code_ff;
        conv_end      = 1'b0;
        unique case (state_ff)
            adc_seq_pkg::ST_IDLE:
            begin
                nxt_div_cnt = 4'h0;
                if (trig_rise)
                begin
                    // settings latched so a mid-cycle write cannot disturb it
                    nxt_div       = safe_div(i_converter_clock_divide);
                    nxt_win       = window_ticks(i_sample_window_prescale);
                    nxt_soc_cnt   = 2'h0;
                    nxt_total_cnt = 10'h001;
                    nxt_state     = adc_seq_pkg::ST_SOC_WAIT;
                end
            end
            adc_seq_pkg::ST_SOC_WAIT:
            begin
                nxt_div_cnt = 4'h0;
                nxt_soc_cnt = soc_cnt_ff + 2'h1;
                if (soc_cnt_ff == 2'(adc_seq_pkg::SOC_DELAY_CYCLES - 1))
                begin
                    nxt_tick_cnt = 6'h00;
                    nxt_state    = adc_seq_pkg::ST_SAMPLE;
                end
            end
            adc_seq_pkg::ST_SAMPLE:
            begin
                if (adc_tick)
                begin
                    nxt_tick_cnt = tick_cnt_ff + 6'h01;
                    if (tick_cnt_ff + 6'h01 == win_ff)
                    begin
                        nxt_code     = i_sample_code;
                        nxt_tick_cnt = 6'h00;
                        nxt_state    = adc_seq_pkg::ST_CONVERT;
                    end
                end
            end
            adc_seq_pkg::ST_CONVERT:
            begin
                if (adc_tick)
                begin
                    nxt_tick_cnt = tick_cnt_ff + 6'h01;
                    if (tick_cnt_ff + 6'h01 == 6'(adc_seq_pkg::CONV_TICKS))
                    begin
                        conv_end  = 1'b1;
                        nxt_state = adc_seq_pkg::ST_EOC_WAIT;
                    end
                end
            end
            adc_seq_pkg::ST_EOC_WAIT:
            begin
                // hold busy until the delayed result load, then pad to the cycle floor
                if (load_pulse)
                    nxt_state = adc_seq_pkg::ST_PAD;
            end
            adc_seq_pkg::ST_PAD:
            begin
                if (total_cnt_ff >= 10'(adc_seq_pkg::CYCLE_MIN_CYCLES))
                    nxt_state = adc_seq_pkg::ST_IDLE;
            end
        endcase
    end

    always_ff @(posedge i_clock or posedge i_sys_rst)
    begin
        if (i_sys_rst)
        begin
            state_ff     <= adc_seq_pkg::ST_IDLE;
            div_ff       <= adc_seq_pkg::CLKDIV_RST;
            div_cnt_ff   <= 4'h0;
            tick_cnt_ff  <= 6'h00;
            win_ff       <= 6'(adc_seq_pkg::SH_MIN_TICKS);
            soc_cnt_ff   <= 2'h0;
            total_cnt_ff <= 10'h000;
            code_ff      <= 10'h000;
        end
        else
        begin
            state_ff     <= nxt_state;
            div_ff       <= nxt_div;
            div_cnt_ff   <= nxt_div_cnt;
            tick_cnt_ff  <= nxt_tick_cnt;
            win_ff       <= nxt_win;
            soc_cnt_ff   <= nxt_soc_cnt;
            total_cnt_ff <= nxt_total_cnt;
            code_ff      <= nxt_code;
        end
    end

    // ****************************************
    // result load, flag and interrupt
    // ****************************************
    logic                             flag_dly;
    logic [adc_seq_pkg::RESULT_W-1:0] result_ff, nxt_result;
    logic                             flag_ff, nxt_flag;
    logic                             irq_ff, nxt_irq;

    adc_delay_line #(.DEPTH(adc_seq_pkg::EOC_DELAY_CYCLES)) u_eoc_delay (
        .i_clock   (i_clock),
        .i_sys_rst (i_sys_rst),
        .i_pulse   (conv_end),
        .o_pulse   (load_pulse)
    );

    adc_delay_line #(.DEPTH(adc_seq_pkg::INT_DELAY_CYCLES)) u_int_delay (
        .i_clock   (i_clock),
        .i_sys_rst (i_sys_rst),
        .i_pulse   (load_pulse),
        .o_pulse   (flag_dly)
    );

    always_comb
    begin
        nxt_result = load_pulse ? code_ff : result_ff;
        // a new completion beats a clear in the same cycle
        nxt_flag   = load_pulse | (flag_ff & ~clr_sync_ff[1]);
        nxt_irq    = flag_dly & i_interrupt_enable;
    end

    always_ff @(posedge i_clock or posedge i_sys_rst)
    begin
        if (i_sys_rst)
        begin
            result_ff <= 10'h000;
            flag_ff   <= 1'b0;
            irq_ff    <= 1'b0;
        end
        else
        begin
            result_ff <= nxt_result;
            flag_ff   <= nxt_flag;
            irq_ff    <= nxt_irq;
        end
    end

    assign o_result           = result_ff;
    assign o_done_flag        = flag_ff;
    assign o_interrupt        = irq_ff;
    assign o_sample_hold      = (state_ff == adc_seq_pkg::ST_SAMPLE);
    assign o_converting       = (state_ff == adc_seq_pkg::ST_CONVERT);
    assign o_busy             = (state_ff != adc_seq_pkg::ST_IDLE);
    assign o_cpu_clock_output = div_cnt_ff < (div_ff >> 1);
endmodule
`default_nettype wire

// file: core/adc_seq_pkg.sv
`default_nettype none
package adc_seq_pkg;
    // ****************************************
    // timing figures
    // ****************************************
    localparam int CLK_PERIOD_PS        = 10000;
    localparam int SOC_DELAY_CYCLES     = 2;
    localparam int EOC_DELAY_CYCLES     = 2;
    localparam int INT_DELAY_CYCLES     = 2;
    localparam int ADC_PERIOD_MIN_PS    = 33300;
    localparam int CYCLE_MIN_NS         = 500;
    localparam int CYCLE_MIN_CYCLES     = (CYCLE_MIN_NS * 1000 + CLK_PERIOD_PS - 1) / CLK_PERIOD_PS;
    // least converter clock divide so its period is not under the floor
    localparam int ADC_DIV_MIN          = (ADC_PERIOD_MIN_PS + CLK_PERIOD_PS - 1) / CLK_PERIOD_PS;
    localparam int SH_MIN_TICKS         = 2;
    localparam int SH_MAX_TICKS         = 32;
    localparam int CONV_TICKS           = 10;

    // ****************************************
    // field layout of control register one
    // ****************************************
    localparam int PRESCALE_W           = 5;
    localparam int CLKDIV_W             = 4;
    localparam int RESULT_W             = 10;
    localparam logic [PRESCALE_W-1:0] PRESCALE_RST = 5'h00;
    localparam logic [CLKDIV_W-1:0]   CLKDIV_RST   = 4'h3;

    typedef enum logic [2:0] {
        ST_IDLE,
        ST_SOC_WAIT,
        ST_SAMPLE,
        ST_CONVERT,
        ST_EOC_WAIT,
        ST_PAD
    } seq_state_t;
endpackage
`default_nettype wire

// file: core/adc_delay_line.sv
`default_nettype none
// fixed-length pulse delay in cpu clocks
module adc_delay_line #(
    parameter int DEPTH = 2
) (
    // clock and reset
    input  wire logic i_clock,
    input  wire logic i_sys_rst,
    // pulse in and out
    input  wire logic i_pulse,
    output logic      o_pulse
);
    logic [DEPTH-1:0] taps_ff;
    logic [DEPTH-1:0] nxt_taps;

    always_comb
    begin
        nxt_taps = {taps_ff[DEPTH-2:0], i_pulse};
    end

    always_ff @(posedge i_clock or posedge i_sys_rst)
    begin
        if (i_sys_rst)
            taps_ff <= '0;
        else
            taps_ff <= nxt_taps;
    end

    assign o_pulse = taps_ff[DEPTH-1];
endmodule
`default_nettype wire

// file: tb/adc_seq_checker_properties.sv
`default_nettype none
module adc_seq_checker (
    input wire logic                             i_clock,
    input wire logic                             i_sys_rst,
    input wire logic                             i_interrupt_enable,
    input wire logic                             o_sample_hold,
    input wire logic                             o_converting,
    input wire logic [adc_seq_pkg::RESULT_W-1:0] o_result,
    input wire logic                             o_busy,
    input wire logic                             o_done_flag,
    input wire logic                             o_interrupt
);
    // ****************************************
    // phase length counters
    // ****************************************
    logic [9:0] sh_ff;
    logic [9:0] cv_ff;
    logic [9:0] bz_ff;
    always_ff @(posedge i_clock or posedge i_sys_rst)
    begin
        if (i_sys_rst)
        begin
            sh_ff <= 10'h000;
            cv_ff <= 10'h000;
            bz_ff <= 10'h000;
        end
        else
        begin
            sh_ff <= o_sample_hold ? sh_ff + 10'h001 : 10'h000;
            cv_ff <= o_converting ? cv_ff + 10'h001 : 10'h000;
            bz_ff <= o_busy ? bz_ff + 10'h001 : 10'h000;
        end
    end
    default clocking @(posedge i_clock);
    endclocking
    default disable iff (i_sys_rst);
    // ****************************************
    // properties
    // ****************************************
    a_soc_delay: assert property ($rose(o_busy) |-> ##2 $rose(o_sample_hold))
        else $error("sample window not two clocks after start");
    // bounds: 2 ticks of the least divide up to 32 ticks of the largest
    a_window_span: assert property ($fell(o_sample_hold) |-> sh_ff >= 8 && sh_ff <= 480)
        else $error("sample window length out of range");
    a_conv_follows: assert property ($fell(o_sample_hold) |-> o_converting)
        else $error("conversion does not follow sample window");
    a_conv_length: assert property ($fell(o_converting) |-> cv_ff >= 40)
        else $error("conversion phase too short");
    a_result_load: assert property ($changed(o_result) |->
        $past(o_converting, 3) && !$past(o_converting, 2))
        else $error("result loaded at wrong time");
    a_flag_timing: assert property ($rose(o_done_flag) |->
        $past(o_converting, 3) && !$past(o_converting, 2))
        else $error("done flag not set with result load");
    a_int_delay: assert property ($rose(o_done_flag) && i_interrupt_enable |->
        ##2 o_interrupt)
        else $error("interrupt missing two clocks after flag");
    a_int_cause: assert property (o_interrupt |-> $past(o_done_flag, 2) ##1 !o_interrupt)
        else $error("interrupt without flag or too long");
    a_cycle_min: assert property ($fell(o_busy) |-> bz_ff >= adc_seq_pkg::CYCLE_MIN_CYCLES)
        else $error("conversion cycle shorter than minimum");
endmodule
bind adc_conversion_sequencer adc_seq_checker adc_seq_checker_i (.i_clock, .i_sys_rst,
    .i_interrupt_enable, .o_sample_hold, .o_converting, .o_result, .o_busy, .o_done_flag,
    .o_interrupt);
`default_nettype wire

// file: tb/test_adc_conversion_sequencer.sv
`default_nettype none
module test_adc_conversion_sequencer;
    timeunit 1ns;
    timeprecision 1ps;
    typedef struct {
        logic [4:0] p;
        logic [3:0] d;
        logic       en;
        logic [9:0] code;
        int         sh;
        int         cv;
    } row_t;
    // divide 0 is forced up to 4 so the converter tick stays legal
    row_t       rows [4] = '{'{5'h00, 4'h0, 1'b1, 10'h3FF, 8, 40},
                             '{5'h05, 4'h4, 1'b0, 10'h000, 28, 40},
                             '{5'h1D, 4'h7, 1'b1, 10'h2A5, 217, 70},
                             '{5'h1F, 4'hF, 1'b1, 10'h15A, 480, 150}};
    logic       i_clock;
    logic       i_sys_rst;
    logic [4:0] i_sample_window_prescale;
    logic [3:0] i_converter_clock_divide;
    logic       i_interrupt_enable;
    logic       i_start_trigger;
    logic       i_flag_clear;
    logic [9:0] i_sample_code;
    logic       o_sample_hold;
    logic       o_converting;
    logic [9:0] o_result;
    logic       o_busy;
    logic       o_done_flag;
    logic       o_interrupt;
    logic       o_cpu_clock_output;
    int         fails = 0;
    int         n_compared = 0;

    adc_conversion_sequencer adc_conversion_sequencer_i (.i_clock, .i_sys_rst,
        .i_sample_window_prescale, .i_converter_clock_divide, .i_interrupt_enable,
        .i_start_trigger, .i_flag_clear, .i_sample_code, .o_sample_hold, .o_converting,
        .o_result, .o_busy, .o_done_flag, .o_interrupt, .o_cpu_clock_output);

    initial
    begin
        i_clock = 1'b0;
        forever #5 i_clock = ~i_clock;
    end

    task automatic end_of_test;
        $display("compared %0d, failed %0d", n_compared, fails);
        if (fails == 0 && n_compared > 0)
            $display("bench passed");
        else
            $display("bench failed");
        $finish;
    endtask

    task automatic chk_num(input int got, input int exp);
        n_compared++;
        if (got != exp)
        begin
            fails++;
            $display("Error at %0t: count %0d, expected %0d", $time, got, exp);
        end
    endtask

    task automatic chk_val(input logic [9:0] got, input logic [9:0] exp);
        n_compared++;
        if (got !== exp)
        begin
            fails++;
            $display("Error at %0t: value %h, expected %h", $time, got, exp);
        end
    endtask

    // ****************************************
    // one conversion, with a retrigger while busy
    // ****************************************
    task automatic run_conv(input row_t r);
        int bs = 0, ss = 0, sh = 0, cv = 0, cl = 0, dt = 0, it = 0, bz = 0;
        int ck = 0, xs = 0, fin = 0;
        logic ck_prev = 1'b0;
        i_sample_window_prescale = r.p;
        i_converter_clock_divide = r.d;
        i_interrupt_enable = r.en;
        i_sample_code = r.code;
        i_start_trigger = 1'b1;
        for (int t = 1; t < 2000; t++)
        begin
            @(posedge i_clock);
            #1;
            if (t == 4 || t == 24) i_start_trigger = 1'b0;
            if (t == 20) i_start_trigger = 1'b1;
            if ($isunknown({o_busy, o_sample_hold, o_converting, o_cpu_clock_output})) xs++;
            if ($isunknown({o_done_flag, o_interrupt})) xs++;
            if (o_busy && bs == 0) bs = t;
            if (o_sample_hold && ss == 0) ss = t;
            sh += o_sample_hold;
            cv += o_converting;
            bz += o_busy;
            if (o_converting) cl = t;
            if (o_done_flag && dt == 0) dt = t;
            if (o_interrupt) it = t;
            // converter clock periods seen inside the conversion phase
            if (o_converting && o_cpu_clock_output && !ck_prev) ck++;
            ck_prev = o_cpu_clock_output;
            if (dt != 0 && t > dt + 4 && !o_busy)
            begin
                fin = 1;
                break;
            end
        end
        chk_num(fin, 1);
        chk_num(xs, 0);
        chk_num(ss - bs, 2);
        chk_num(sh, r.sh);
        chk_num(cv, r.cv);
        chk_num(dt - cl, 3);
        chk_val(o_result, r.code);
        chk_num(it, r.en ? dt + 2 : 0);
        chk_num(ck, adc_seq_pkg::CONV_TICKS);
        chk_num(int'(bz >= adc_seq_pkg::CYCLE_MIN_CYCLES), 1);
        i_flag_clear = 1'b1;
        repeat (5) @(posedge i_clock);
        #1;
        chk_val({8'h00, o_done_flag, o_busy}, 10'h000);
        i_flag_clear = 1'b0;
    endtask

    initial
    begin
        {i_sample_window_prescale, i_converter_clock_divide, i_interrupt_enable} = 10'h000;
        {i_start_trigger, i_flag_clear, i_sample_code} = 12'h000;
        i_sys_rst = 1'b1;
        repeat (20) @(posedge i_clock);
        #1;
        i_sys_rst = 1'b0;
        chk_val(o_result, 10'h000);
        chk_val({7'h00, o_busy, o_done_flag, o_interrupt}, 10'h000);
        foreach (rows[k]) run_conv(rows[k]);
        // clear held through a completion: the set still shows for a cycle
        @(posedge i_clock);
        #1;
        i_flag_clear = 1'b1;
        run_conv(rows[2]);
        // reset in mid-cycle, then a clean conversion
        i_start_trigger = 1'b1;
        repeat (15) @(posedge i_clock);
        #1;
        i_sys_rst = 1'b1;
        @(posedge i_clock);
        #1;
        chk_val({7'h00, o_busy, o_sample_hold, o_converting}, 10'h000);
        i_sys_rst = 1'b0;
        i_start_trigger = 1'b0;
        @(posedge i_clock);
        #1;
        run_conv(rows[0]);
        end_of_test;
    end

    initial
    begin
        #(30000 * 10);
        fails++;
        end_of_test;
    end
endmodule
`default_nettype wire
